// >>> hw/sspc_pkg.sv
`default_nettype none
package sspc_pkg;
	// ****************************************
	// register map
	// ****************************************
	localparam logic [7:0] PIN_SEL_OFFSET = 8'h03; // holds the role swap bit
	localparam logic [7:0] PULL_OFFSET = 8'h04; // pull disable register
	localparam logic [7:0] RESERVED_OFFSET = 8'h05; // reads as zero
	localparam int ADDR_W = 8;
	localparam int DATA_W = 8;
	localparam int PORT_N = 4;
	// ****************************************
	// field positions and reset values
	// ****************************************
	localparam int SWAP_BIT = 3;
	localparam int UP_LSB = 0;
	localparam int DOWN_LSB = 4;
	localparam logic [7:0] PULL_RESET = 8'h00;
	localparam logic SWAP_RESET = 1'b0;
	localparam logic [7:0] PIN_SEL_RW_MASK = 8'h08;
endpackage
`default_nettype wire

// >>> hw/sspc_spi_if.sv
`timescale 1ns/1ps
`default_nettype none
// spi signal groups between the pad mux and its user side
interface sspc_spi_if;
	logic master_chip_select;
	logic master_serial_clock;
	logic master_out_line;
	logic master_in_line;
	logic slave_chip_select;
	logic slave_serial_clock;
	logic slave_in_line;
	logic slave_out_line;
	logic [3:0] p0_hi_out;
	logic [3:0] p0_hi_oe;
	logic [3:0] p0_hi_in;
	logic [3:0] p3_lo_out;
	logic [3:0] p3_lo_oe;
	logic [3:0] p3_lo_in;
	logic swap;
	modport mux (
		input master_chip_select, master_serial_clock, master_out_line,
		input slave_out_line, swap, p0_hi_in, p3_lo_in,
		output master_in_line, slave_chip_select, slave_serial_clock, slave_in_line,
		output p0_hi_out, p0_hi_oe, p3_lo_out, p3_lo_oe
	);
	modport top (
		output master_chip_select, master_serial_clock, master_out_line,
		output slave_out_line, swap, p0_hi_in, p3_lo_in,
		input master_in_line, slave_chip_select, slave_serial_clock, slave_in_line,
		input p0_hi_out, p0_hi_oe, p3_lo_out, p3_lo_oe
	);
endinterface
`default_nettype wire

// >>> hw/sspc_spi_swap.sv
`timescale 1ns/1ps
`default_nettype none
// ****************************************
// spi role swap pad mux
// ****************************************
module sspc_spi_swap (
	sspc_spi_if.mux spi // spi groups and pad sides
);
	// master group lines in pin order: select, clock, out, in
	wire [3:0] master_out_grp;
	wire [3:0] master_oe_grp;
	wire [3:0] slave_out_grp;
	wire [3:0] slave_oe_grp;
	wire [3:0] master_pin_in;
	wire [3:0] slave_pin_in;
	assign master_out_grp = {1'b0, spi.master_out_line, spi.master_serial_clock, spi.master_chip_select};
	assign master_oe_grp = 4'h7; // master drives select, clock, out
	assign slave_out_grp = {spi.slave_out_line, 3'h0};
	assign slave_oe_grp = 4'h8; // slave drives only its out line
	// swap exchanges whole groups between the two pin sets
	assign spi.p0_hi_out = spi.swap ? slave_out_grp : master_out_grp;
	assign spi.p0_hi_oe = spi.swap ? slave_oe_grp : master_oe_grp;
	assign spi.p3_lo_out = spi.swap ? master_out_grp : slave_out_grp;
	assign spi.p3_lo_oe = spi.swap ? master_oe_grp : slave_oe_grp;
	assign master_pin_in = spi.swap ? spi.p3_lo_in : spi.p0_hi_in;
	assign slave_pin_in = spi.swap ? spi.p0_hi_in : spi.p3_lo_in;
	assign spi.master_in_line = master_pin_in[3];
	assign spi.slave_chip_select = slave_pin_in[0];
	assign spi.slave_serial_clock = slave_pin_in[1];
	assign spi.slave_in_line = slave_pin_in[2];
endmodule
`default_nettype wire

// >>> hw/sspc_top.sv
`timescale 1ns/1ps
`default_nettype none
// Operation
// - pull register bits 0..3 govern upstream ports 0..3 d+ pull-up
// - upstream disable bit 1 forces the 1.5k pull-up off
// - upstream disable bit 0 lets hardware switch pull-up automatically
// - pull register bits 4..7 govern downstream ports 0..3 pull-downs
// - downstream disable bit 1 keeps both 15k pull-downs off
// - downstream disable bit 0 keeps both 15k pull-downs on
module sspc_top (
	input wire logic sys_clk_i, // 125 mhz system clock
	input wire logic arst_n_i, // async reset, active low
	input wire logic [7:0] reg_addr_i, // register address
	input wire logic [7:0] reg_wdata_i, // write data
	input wire logic reg_wr_i, // write strobe
	input wire logic reg_rd_i, // read strobe
	output logic [7:0] reg_rdata_o, // read data, cycle after strobe
	input wire logic [3:0] up_pullup_req_i, // hardware pull-up request per upstream port
	output logic [3:0] up_pullup_en_o, // upstream d+ 1.5k pull-up enable
	output logic [3:0] down_pulldown_en_o, // downstream d+/d- 15k pull-down enable
	input wire logic master_chip_select_i, // spi master select from core
	input wire logic master_serial_clock_i, // spi master clock from core
	input wire logic master_out_line_i, // spi master data out
	output logic master_in_line_o, // spi master data in
	output logic slave_chip_select_o, // spi slave select to core
	output logic slave_serial_clock_o, // spi slave clock to core
	output logic slave_in_line_o, // spi slave data in
	input wire logic slave_out_line_i, // spi slave data out
	input wire logic [3:0] p0_hi_pin_i, // pins P04..P07 input
	output logic [3:0] p0_hi_pin_o, // pins P04..P07 output
	output logic [3:0] p0_hi_pin_oe_o, // pins P04..P07 output enable
	input wire logic [3:0] p3_lo_pin_i, // pins P30..P33 input
	output logic [3:0] p3_lo_pin_o, // pins P30..P33 output
	output logic [3:0] p3_lo_pin_oe_o // pins P30..P33 output enable
);
	// ****************************************
	// register bus
	// ****************************************
	logic [7:0] pull_q;
	logic [7:0] pull_d;
	logic swap_q;
	logic swap_d;
	logic [7:0] rdata_q;
	logic [7:0] rdata_d;
	wire sel_pin = (reg_addr_i == sspc_pkg::PIN_SEL_OFFSET);
	wire sel_pull = (reg_addr_i == sspc_pkg::PULL_OFFSET);
	wire [7:0] pin_sel_view = {4'h0, swap_q, 3'h0};
	// next values: writes take effect next edge, reserved bits dropped
	assign pull_d = (reg_wr_i && sel_pull) ? reg_wdata_i : pull_q;
	assign swap_d = (reg_wr_i && sel_pin) ? reg_wdata_i[sspc_pkg::SWAP_BIT] : swap_q;
	// unmapped addresses read zero; other pin-select bits live elsewhere
	assign rdata_d = !reg_rd_i ? 8'h00 : sel_pull ? pull_q : sel_pin ? pin_sel_view : 8'h00;
	// register state, cleared at reset
	always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			pull_q <= sspc_pkg::PULL_RESET;
			swap_q <= sspc_pkg::SWAP_RESET;
			rdata_q <= 8'h00;
		end else begin
			pull_q <= pull_d;
			swap_q <= swap_d;
			rdata_q <= rdata_d;
		end
	end
	assign reg_rdata_o = rdata_q;
	// ****************************************
	// pull resistor control
	// ****************************************
	// hardware request is an async pad-side level, synchronised first
	logic [3:0] req_meta_q;
	logic [3:0] req_sync_q;
	always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			req_meta_q <= 4'h0;
			req_sync_q <= 4'h0;
		end else begin
			req_meta_q <= up_pullup_req_i;
			req_sync_q <= req_meta_q;
		end
	end
	wire [3:0] up_off = pull_q[sspc_pkg::UP_LSB +: sspc_pkg::PORT_N];
	wire [3:0] down_off = pull_q[sspc_pkg::DOWN_LSB +: sspc_pkg::PORT_N];
	logic [3:0] up_en_q;
	logic [3:0] down_en_q;
	// per-port gating; outputs registered so pads see no glitches
	for (genvar i = 0; i < sspc_pkg::PORT_N; i++) begin : g_port
		always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
			if (!arst_n_i) begin
				up_en_q[i] <= 1'b0;
				down_en_q[i] <= 1'b0;
			end else begin
				up_en_q[i] <= !up_off[i] && req_sync_q[i];
				down_en_q[i] <= !down_off[i];
			end
		end
	end
	assign up_pullup_en_o = up_en_q;
	assign down_pulldown_en_o = down_en_q;
	// ****************************************
	// spi role swap
	// ****************************************
	sspc_spi_if spi ();
	// pad inputs pass two flops before the mux reads them
	logic [3:0] p0_meta_q;
	logic [3:0] p0_sync_q;
	logic [3:0] p3_meta_q;
	logic [3:0] p3_sync_q;
	always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			p0_meta_q <= 4'h0;
			p0_sync_q <= 4'h0;
			p3_meta_q <= 4'h0;
			p3_sync_q <= 4'h0;
		end else begin
			p0_meta_q <= p0_hi_pin_i;
			p0_sync_q <= p0_meta_q;
			p3_meta_q <= p3_lo_pin_i;
			p3_sync_q <= p3_meta_q;
		end
	end
	assign spi.master_chip_select = master_chip_select_i;
	assign spi.master_serial_clock = master_serial_clock_i;
	assign spi.master_out_line = master_out_line_i;
	assign spi.slave_out_line = slave_out_line_i;
	assign spi.swap = swap_q;
	assign spi.p0_hi_in = p0_sync_q;
	assign spi.p3_lo_in = p3_sync_q;
	sspc_spi_swap u_swap (
		.spi (spi)
	);
	assign master_in_line_o = spi.master_in_line;
	assign slave_chip_select_o = spi.slave_chip_select;
	assign slave_serial_clock_o = spi.slave_serial_clock;
	assign slave_in_line_o = spi.slave_in_line;
	assign p0_hi_pin_o = spi.p0_hi_out;
	assign p0_hi_pin_oe_o = spi.p0_hi_oe;
	assign p3_lo_pin_o = spi.p3_lo_out;
	assign p3_lo_pin_oe_o = spi.p3_lo_oe;
	// ****************************************
	// assertions
	// ****************************************
	up_forced_off_a: assert property (@(posedge sys_clk_i) disable iff (!arst_n_i)
		pull_q[0] |=> !up_pullup_en_o[0])
		else $error("upstream 0 pull-up on while disabled");
	up_follows_hw_a: assert property (@(posedge sys_clk_i) disable iff (!arst_n_i)
		(!pull_q[1] && req_sync_q[1]) |=> up_pullup_en_o[1])
		else $error("upstream 1 pull-up not following hardware");
	up_bit_map_a: assert property (@(posedge sys_clk_i) disable iff (!arst_n_i)
		(reg_wr_i && sel_pull && reg_wdata_i[3]) |=> ##1 !up_pullup_en_o[3])
		else $error("bit 3 does not govern upstream 3");
	down_off_a: assert property (@(posedge sys_clk_i) disable iff (!arst_n_i)
		(reg_wr_i && sel_pull && reg_wdata_i[7]) |=> ##1 !down_pulldown_en_o[3])
		else $error("downstream 3 pull-down not off");
	down_on_a: assert property (@(posedge sys_clk_i) disable iff (!arst_n_i)
		!pull_q[4] |=> down_pulldown_en_o[0])
		else $error("downstream 0 pull-down not on");
	// skip the first edge after reset, the pull-downs still show their reset level there
	down_bit_map_a: assert property (@(posedge sys_clk_i) disable iff (!arst_n_i)
		$past(arst_n_i) |-> $past(pull_q[6]) != down_pulldown_en_o[2])
		else $error("bit 6 does not govern downstream 2");
	swap_pins_a: assert property (@(posedge sys_clk_i) disable iff (!arst_n_i)
		swap_q |-> (p3_lo_pin_o[1] == master_serial_clock_i && p0_hi_pin_oe_o == 4'h8))
		else $error("swapped master clock not on P31");
	pin_sel_read_a: assert property (@(posedge sys_clk_i) disable iff (!arst_n_i)
		(reg_rd_i && sel_pin) |=> reg_rdata_o[7:4] == 4'h0 && reg_rdata_o[3] == $past(swap_q))
		else $error("pin select readback wrong");
	// per-port checks on more of the cases the first group leaves out; upstream 1 off and downstream 1 on stay unchecked
	up_two_off_a: assert property (@(posedge sys_clk_i) disable iff (!arst_n_i)
		pull_q[2] |=> !up_pullup_en_o[2])
		else $error("upstream 2 pull-up on while disabled");
	up_three_hw_a: assert property (@(posedge sys_clk_i) disable iff (!arst_n_i)
		(!pull_q[3] && req_sync_q[3]) |=> up_pullup_en_o[3])
		else $error("upstream 3 pull-up not following hardware");
	up_hw_release_a: assert property (@(posedge sys_clk_i) disable iff (!arst_n_i)
		(!pull_q[2] && !req_sync_q[2]) |=> !up_pullup_en_o[2])
		else $error("upstream 2 pull-up on without hardware request");
	down_zero_off_a: assert property (@(posedge sys_clk_i) disable iff (!arst_n_i)
		pull_q[4] |=> !down_pulldown_en_o[0])
		else $error("downstream 0 pull-down not off");
	down_one_off_a: assert property (@(posedge sys_clk_i) disable iff (!arst_n_i)
		pull_q[5] |=> !down_pulldown_en_o[1])
		else $error("downstream 1 pull-down not off");
	down_three_on_a: assert property (@(posedge sys_clk_i) disable iff (!arst_n_i)
		!pull_q[7] |=> down_pulldown_en_o[3])
		else $error("downstream 3 pull-down not on");
	// register bus checks
	pull_write_a: assert property (@(posedge sys_clk_i) disable iff (!arst_n_i)
		(reg_wr_i && sel_pull) |=> pull_q == $past(reg_wdata_i))
		else $error("pull register write lost");
	pull_read_a: assert property (@(posedge sys_clk_i) disable iff (!arst_n_i)
		(reg_rd_i && sel_pull) |=> reg_rdata_o == $past(pull_q))
		else $error("pull register readback wrong");
	swap_write_a: assert property (@(posedge sys_clk_i) disable iff (!arst_n_i)
		(reg_wr_i && sel_pin) |=> swap_q == $past(reg_wdata_i[sspc_pkg::SWAP_BIT]))
		else $error("swap select write lost");
	unmapped_read_a: assert property (@(posedge sys_clk_i) disable iff (!arst_n_i)
		(reg_rd_i && !sel_pin && !sel_pull) |=> reg_rdata_o == 8'h00)
		else $error("unmapped read not zero");
	// pad mux checks in both swap settings
	plain_pins_a: assert property (@(posedge sys_clk_i) disable iff (!arst_n_i)
		!swap_q |-> (p0_hi_pin_oe_o == 4'h7 && p3_lo_pin_oe_o == 4'h8
			&& p0_hi_pin_o[1] == master_serial_clock_i))
		else $error("master clock not on P05 while unswapped");
	swap_inputs_a: assert property (@(posedge sys_clk_i) disable iff (!arst_n_i)
		swap_q |-> (slave_chip_select_o == p0_sync_q[0] && master_in_line_o == p3_sync_q[3]))
		else $error("swapped pin inputs routed wrong");
	plain_inputs_a: assert property (@(posedge sys_clk_i) disable iff (!arst_n_i)
		!swap_q |-> (master_in_line_o == p0_sync_q[3] && slave_serial_clock_o == p3_sync_q[1]))
		else $error("unswapped pin inputs routed wrong");
	pull_write_c: cover property (@(posedge sys_clk_i) disable iff (!arst_n_i)
		reg_wr_i && sel_pull && reg_wdata_i == 8'hff);
	swap_set_c: cover property (@(posedge sys_clk_i) disable iff (!arst_n_i) $rose(swap_q));
	hw_pullup_c: cover property (@(posedge sys_clk_i) disable iff (!arst_n_i) $rose(up_pullup_en_o[0]));
	swap_clear_c: cover property (@(posedge sys_clk_i) disable iff (!arst_n_i) $fell(swap_q));
	down_off_c: cover property (@(posedge sys_clk_i) disable iff (!arst_n_i) $fell(down_pulldown_en_o[3]));
endmodule
`default_nettype wire

// >>> dv/tb_sspc_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_sspc_top;
	logic sys_clk_i, arst_n_i, reg_wr_i, reg_rd_i;
	logic [7:0] reg_addr_i, reg_wdata_i, reg_rdata_o;
	logic [3:0] up_pullup_req_i, up_pullup_en_o, down_pulldown_en_o;
	logic master_chip_select_i, master_serial_clock_i, master_out_line_i, master_in_line_o;
	logic slave_chip_select_o, slave_serial_clock_o, slave_in_line_o, slave_out_line_i;
	logic [3:0] p0_hi_pin_i, p0_hi_pin_o, p0_hi_pin_oe_o, p3_lo_pin_i, p3_lo_pin_o, p3_lo_pin_oe_o;
	int bad_count, num_checks, cyc;
	sspc_top dut (.sys_clk_i(sys_clk_i), .arst_n_i(arst_n_i), .reg_addr_i(reg_addr_i),
		.reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o),
		.up_pullup_req_i(up_pullup_req_i), .up_pullup_en_o(up_pullup_en_o),
		.down_pulldown_en_o(down_pulldown_en_o), .master_chip_select_i(master_chip_select_i),
		.master_serial_clock_i(master_serial_clock_i), .master_out_line_i(master_out_line_i),
		.master_in_line_o(master_in_line_o), .slave_chip_select_o(slave_chip_select_o),
		.slave_serial_clock_o(slave_serial_clock_o), .slave_in_line_o(slave_in_line_o),
		.slave_out_line_i(slave_out_line_i), .p0_hi_pin_i(p0_hi_pin_i), .p0_hi_pin_o(p0_hi_pin_o),
		.p0_hi_pin_oe_o(p0_hi_pin_oe_o), .p3_lo_pin_i(p3_lo_pin_i), .p3_lo_pin_o(p3_lo_pin_o),
		.p3_lo_pin_oe_o(p3_lo_pin_oe_o));
	// ****************************************
	// clock, watchdog and shared tasks
	// ****************************************
	initial begin
		sys_clk_i = 1'b0;
		forever #4 sys_clk_i = ~sys_clk_i;
	end
	// whole run needs well under a thousand cycles
	always @(posedge sys_clk_i) begin
		cyc++;
		if (cyc == 3000) begin
			bad_count++;
			$display("ERROR %0t run did not finish", $time);
			end_sim();
		end
	end
	task automatic end_sim();
		if (bad_count == 0 && num_checks > 0) $display("Test passed");
		else $display("Test failed");
		$finish;
	endtask
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		num_checks++;
		if (got !== exp) begin
			bad_count++;
			$display("ERROR %0t got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic do_reset();
		up_pullup_req_i <= 4'h0;
		arst_n_i <= 1'b0;
		repeat (8) @(posedge sys_clk_i);
		arst_n_i <= 1'b1;
		repeat (3) @(posedge sys_clk_i);
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge sys_clk_i);
		reg_addr_i <= a;
		reg_wdata_i <= d;
		reg_wr_i <= 1'b1;
		@(posedge sys_clk_i);
		reg_wr_i <= 1'b0;
	endtask
	// read data stand only in the cycle after the strobe
	task automatic rd(input logic [7:0] a, input logic [7:0] exp);
		@(posedge sys_clk_i);
		reg_addr_i <= a;
		reg_rd_i <= 1'b1;
		@(posedge sys_clk_i);
		reg_rd_i <= 1'b0;
		#1 chk(reg_rdata_o, exp);
	endtask
	// ****************************************
	// scenarios
	// ****************************************
	task automatic t_reset();
		rd(sspc_pkg::PULL_OFFSET, 8'h00);
		rd(sspc_pkg::PIN_SEL_OFFSET, 8'h00);
		chk({down_pulldown_en_o, up_pullup_en_o}, 8'hf0);
	endtask
	// reserved bits and unmapped space must swallow writes
	task automatic t_reserved();
		wr(sspc_pkg::PIN_SEL_OFFSET, 8'hff);
		rd(sspc_pkg::PIN_SEL_OFFSET, 8'h08);
		wr(sspc_pkg::RESERVED_OFFSET, 8'hff);
		rd(sspc_pkg::RESERVED_OFFSET, 8'h00);
		wr(sspc_pkg::PIN_SEL_OFFSET, 8'h00);
	endtask
	// walking one over the pull register, hardware asking for all pull-ups
	task automatic t_pull();
		logic [7:0] v;
		@(posedge sys_clk_i);
		up_pullup_req_i <= 4'hf;
		for (int i = 0; i < 9; i++) begin
			v = (i == 8) ? 8'hff : (8'h01 << i);
			wr(sspc_pkg::PULL_OFFSET, v);
			repeat (3) @(posedge sys_clk_i);
			#1 chk({down_pulldown_en_o, up_pullup_en_o}, ~v);
			rd(sspc_pkg::PULL_OFFSET, v);
		end
	endtask
	// ports 0 and 2 forced off, ports 1 and 3 follow the request
	task automatic t_hwreq();
		logic [3:0] pat [3] = '{4'h0, 4'hf, 4'ha};
		wr(sspc_pkg::PULL_OFFSET, 8'h05);
		for (int i = 0; i < 3; i++) begin
			@(posedge sys_clk_i);
			up_pullup_req_i <= pat[i];
			repeat (4) @(posedge sys_clk_i);
			#1 chk({4'h0, up_pullup_en_o}, {4'h0, pat[i] & 4'ha});
		end
	endtask
	task automatic t_spi(input logic sw);
		logic [3:0] mo, moe, so, soe;
		wr(sspc_pkg::PIN_SEL_OFFSET, {4'h0, sw, 3'h0});
		for (int k = 0; k < 16; k++) begin
			@(posedge sys_clk_i);
			{slave_out_line_i, master_out_line_i, master_serial_clock_i, master_chip_select_i} <= 4'(k);
			p0_hi_pin_i <= 4'(k);
			p3_lo_pin_i <= ~4'(k);
			repeat (3) @(posedge sys_clk_i);
			#1;
			mo = sw ? p3_lo_pin_o : p0_hi_pin_o;
			moe = sw ? p3_lo_pin_oe_o : p0_hi_pin_oe_o;
			so = sw ? p0_hi_pin_o : p3_lo_pin_o;
			soe = sw ? p0_hi_pin_oe_o : p3_lo_pin_oe_o;
			chk({moe, mo & 4'h7}, {4'h7, 1'b0, 3'(k)});
			chk({soe, so & 4'h8}, {4'h8, 4'(k) & 4'h8});
			chk({4'h0, master_in_line_o, slave_in_line_o, slave_serial_clock_o, slave_chip_select_o},
				{4'h0, sw ? ~k[3] : k[3], sw ? 3'(k) : ~3'(k)});
		end
	endtask
	// ****************************************
	// main sequence
	// ****************************************
	initial begin
		arst_n_i = 1'b0;
		reg_addr_i = 8'h00;
		reg_wdata_i = 8'h00;
		reg_wr_i = 1'b0;
		reg_rd_i = 1'b0;
		up_pullup_req_i = 4'h0;
		{master_chip_select_i, master_serial_clock_i, master_out_line_i, slave_out_line_i} = 4'h0;
		p0_hi_pin_i = 4'h0;
		p3_lo_pin_i = 4'h0;
		do_reset();
		t_reset();
		t_reserved();
		t_pull();
		t_hwreq();
		t_spi(1'b0);
		t_spi(1'b1);
		wr(sspc_pkg::PULL_OFFSET, 8'hff);
		do_reset();
		t_reset();
		end_sim();
	end
endmodule
`default_nettype wire
